// [common/interrupt_source_vector_map_params.svh]
// constants for the interrupt source and vector map block
`ifndef INTERRUPT_SOURCE_VECTOR_MAP_PARAMS_SVH
`define INTERRUPT_SOURCE_VECTOR_MAP_PARAMS_SVH

// fixed vector start addresses
`define VEC_UNDEF       20'hF_FFDC
`define VEC_OVERFLOW    20'hF_FFE0
`define VEC_BREAK       20'hF_FFE4
`define VEC_MATCH       20'hF_FFE8
`define VEC_STEP        20'hF_FFEC
`define VEC_WATCHDOG    20'hF_FFF0
`define VEC_DEBUG_BREAK 20'hF_FFF4
`define VEC_RESERVED    20'hF_FFF8
`define VEC_RESET       20'hF_FFFC

// fixed breakpoint vector contents that redirect to the variable table
`define BRK_VEC_BLANK   32'hFFFF_FFFF

// variable vector numbers
`define NUM_KEY         5'h0D
`define NUM_AD          5'h0E
`define NUM_UART0_TX    5'h11
`define NUM_UART0_RX    5'h12
`define NUM_UART1_TX    5'h13
`define NUM_UART1_RX    5'h14
`define NUM_TIMER_A0    5'h15
`define NUM_TIMER_X0    5'h16
`define NUM_TIMER_B0    5'h1A
`define NUM_EXT0        5'h1D
`define NUM_BREAK_VAR   6'h00

// level reported for non-maskable sources, and stack-select flag value loaded at reset
`define NMI_LEVEL       3'h7
`define U_FLAG_RESET    1'b0

`endif

// [common/interrupt_source_vector_map_pkg.sv]
// types for the interrupt source and vector map block
package interrupt_source_vector_map_pkg;

    typedef enum logic [2:0] {
        IK_NONE,
        IK_UNDEF,
        IK_OVERFLOW,
        IK_BREAK,
        IK_TRAP
    } insn_kind_e;

    typedef enum logic [3:0] {
        SRC_NONE,
        SRC_RESET,
        SRC_UNDEF,
        SRC_OVERFLOW,
        SRC_BREAK,
        SRC_TRAP,
        SRC_DEBUG_BREAK,
        SRC_WATCHDOG,
        SRC_MATCH,
        SRC_STEP,
        SRC_MASKABLE
    } src_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OFFER,
        ST_HOLD_RESET
    } state_e;

    typedef struct packed {
        logic       ad_done;
        logic       uart0_tx;
        logic       uart0_rx;
        logic       uart1_tx;
        logic       uart1_rx;
        logic       timer_a0;
        logic [2:0] timer_x;
        logic [1:0] timer_b;
    } periph_evt_s;

    typedef struct packed {
        state_e      st;
        logic [31:0] req;
        logic [1:0]  ext_prev;
        logic        key_prev;
        logic        p_undef;
        logic        p_ovf;
        logic        p_brk;
        logic        p_trap;
        logic [5:0]  trap_num;
        logic        p_dbg;
        logic        p_wdt;
        logic        p_match;
        logic        p_step;
        src_e        offer_src;
        logic [5:0]  offer_num;
        logic [2:0]  offer_lvl;
        logic [19:0] offer_vec;
        logic        u_flag;
        logic        u_saved;
        logic        dev_reset;
    } state_s;

endpackage

// [design/interrupt_source_vector_map.sv]
// interrupt source classification and vector resolution
// Behaviour
// - trap instructions are non-maskable; enable flag and levels never block them
// - undefined-opcode instruction raises the undefined instruction interrupt
// - overflow trap instruction raises overflow interrupt only when overflow flag is 1
// - breakpoint instruction always raises the breakpoint interrupt
// - software trap takes numbers 0..63; 0..31 share peripheral vectors
// - traps 0..31 save stack-select flag, clear it, restore on return
// - traps 32..63 leave the stack-select flag unchanged
// - reset, watchdog, single step, address match, debugger break are non-maskable
// - low level on reset pin puts the device into reset
// - debug step flag set raises single-step interrupt after each instruction
// - match enabled raises match interrupt before instruction at match address
// - peripheral interrupts are maskable and use vectors 0..31
// - falling edge on key input pin raises key-input interrupt
// - external request pins raise on a chosen rising or falling edge
// - fixed vectors occupy FFFDC..FFFFF, four bytes each
// - undefined at FFFDC, overflow at FFFE0, breakpoint at FFFE4
// - address match at FFFE8, single step at FFFEC, watchdog at FFFF0
// - debugger break at FFFF4, reset at FFFFC, slot between reserved
// - blank fixed breakpoint vector redirects to variable entry 0
// - variable table is 256 bytes at base pointer, entry n at 4n
// - key 13, A-D 14, UART0 17/18, UART1 19/20
// - timer A0 21, X0..X2 22..24, B 26/27, external pins 29/30
// - maskable accepted only with enable flag, request bit, level above processor level
// - on acceptance the request bit of that source is cleared by hardware
`include "interrupt_source_vector_map_params.svh"
`timescale 1ns/1ps
`default_nettype none

module interrupt_source_vector_map
    import interrupt_source_vector_map_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              reset_pin_n,
    input  wire logic              insn_start,
    input  wire logic [19:0]       insn_addr,
    input  wire logic              insn_done,
    input  wire insn_kind_e        insn_kind,
    input  wire logic [5:0]        insn_trap_num,
    input  wire logic              overflow_flag,
    input  wire logic              debug_step_flag,
    input  wire logic              match_enable,
    input  wire logic [19:0]       match_addr,
    input  wire logic              watchdog_expire,
    input  wire logic              debugger_break,
    input  wire logic              key_input_pin,
    input  wire logic              ext_request0_pin,
    input  wire logic              ext_request1_pin,
    input  wire logic [1:0]        ext_rise_sel,
    input  wire periph_evt_s       periph_evt,
    input  wire logic [31:0][2:0]  prio_level,
    input  wire logic [31:0]       req_clear,
    input  wire logic              int_enable_flag,
    input  wire logic [2:0]        processor_priority_level,
    input  wire logic [19:0]       vector_base_pointer,
    input  wire logic [31:0]       brk_fixed_vector,
    input  wire logic              stack_sel_in,
    input  wire logic              stack_sel_load,
    input  wire logic              return_from_int,
    input  wire logic              irq_ack,
    output logic                   irq_valid,
    output src_e                   irq_src,
    output logic [5:0]             irq_num,
    output logic [2:0]             irq_level,
    output logic [19:0]            irq_vector,
    output logic                   stack_sel_flag,
    output logic [31:0]            req_bits,
    output logic                   dev_reset
);

    state_s      s_r;
    state_s      s_nxt;
    logic [31:0] set_vec;
    logic [31:0] eligible;
    logic [1:0]  ext_now;
    logic        soft_any;

    assign ext_now  = {ext_request1_pin, ext_request0_pin};
    assign soft_any = s_r.p_undef | s_r.p_ovf | s_r.p_brk | s_r.p_trap;

    // per-bit request set and eligibility
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_req
            localparam int ext_idx = (gi == 32'(`NUM_EXT0) + 1) ? 1 : 0;
            logic hit;
            always_comb begin
                hit = 1'b0;
                case (gi)
                    32'(`NUM_KEY):         hit = s_r.key_prev & ~key_input_pin;
                    32'(`NUM_AD):          hit = periph_evt.ad_done;
                    32'(`NUM_UART0_TX):    hit = periph_evt.uart0_tx;
                    32'(`NUM_UART0_RX):    hit = periph_evt.uart0_rx;
                    32'(`NUM_UART1_TX):    hit = periph_evt.uart1_tx;
                    32'(`NUM_UART1_RX):    hit = periph_evt.uart1_rx;
                    32'(`NUM_TIMER_A0):    hit = periph_evt.timer_a0;
                    32'(`NUM_TIMER_X0):    hit = periph_evt.timer_x[0];
                    32'(`NUM_TIMER_X0) + 1: hit = periph_evt.timer_x[1];
                    32'(`NUM_TIMER_X0) + 2: hit = periph_evt.timer_x[2];
                    32'(`NUM_TIMER_B0):    hit = periph_evt.timer_b[0];
                    32'(`NUM_TIMER_B0) + 1: hit = periph_evt.timer_b[1];
                    32'(`NUM_EXT0), 32'(`NUM_EXT0) + 1: begin
                        // chosen edge only
                        hit = ext_rise_sel[ext_idx]
                            ? (ext_now[ext_idx] & ~s_r.ext_prev[ext_idx])
                            : (~ext_now[ext_idx] & s_r.ext_prev[ext_idx]);
                    end
                    default:               hit = 1'b0;
                endcase
            end
            assign set_vec[gi]  = hit;
            assign eligible[gi] = s_r.req[gi] & int_enable_flag
                                & (prio_level[gi] > processor_priority_level);
        end
    endgenerate

    // vector resolution for a source
    function automatic logic [19:0] vec_of(input src_e src, input logic [5:0] num);
        logic [19:0] var_vec;
        var_vec = vector_base_pointer + {12'h000, num, 2'b00};
        case (src)
            SRC_RESET:       vec_of = `VEC_RESET;
            SRC_UNDEF:       vec_of = `VEC_UNDEF;
            SRC_OVERFLOW:    vec_of = `VEC_OVERFLOW;
            SRC_BREAK:       vec_of = (brk_fixed_vector == `BRK_VEC_BLANK)
                                    ? vector_base_pointer : `VEC_BREAK;
            SRC_MATCH:       vec_of = `VEC_MATCH;
            SRC_STEP:        vec_of = `VEC_STEP;
            SRC_WATCHDOG:    vec_of = `VEC_WATCHDOG;
            SRC_DEBUG_BREAK: vec_of = `VEC_DEBUG_BREAK;
            default:         vec_of = var_vec;
        endcase
    endfunction

    always_comb begin
        logic [2:0] best_lvl;
        logic [4:0] best_num;
        logic       best_hit;
        s_nxt    = s_r;
        best_lvl = 3'h0;
        best_num = 5'h00;
        best_hit = 1'b0;
        // highest level wins, lowest number breaks ties
        for (int i = 31; i >= 0; i--) begin
            if (eligible[i] && (!best_hit || prio_level[i] >= best_lvl)) begin
                best_hit = 1'b1;
                best_lvl = prio_level[i];
                best_num = 5'(i);
            end
        end

        s_nxt.ext_prev = ext_now;
        s_nxt.key_prev = key_input_pin;
        // hardware set wins over software clear
        s_nxt.req = (s_r.req & ~req_clear) | set_vec;

        if (insn_done) begin
            case (insn_kind)
                IK_UNDEF:    s_nxt.p_undef = 1'b1;
                IK_OVERFLOW: s_nxt.p_ovf = s_r.p_ovf | overflow_flag;
                IK_BREAK:    s_nxt.p_brk = 1'b1;
                IK_TRAP: begin
                    s_nxt.p_trap   = 1'b1;
                    s_nxt.trap_num = insn_trap_num;
                end
                default: ;
            endcase
            if (debug_step_flag) begin
                s_nxt.p_step = 1'b1;
            end
        end
        if (insn_start && match_enable && insn_addr == match_addr) begin
            s_nxt.p_match = 1'b1;
        end
        if (watchdog_expire) begin
            s_nxt.p_wdt = 1'b1;
        end
        if (debugger_break) begin
            s_nxt.p_dbg = 1'b1;
        end
        if (stack_sel_load) begin
            s_nxt.u_flag = stack_sel_in;
        end
        if (return_from_int) begin
            s_nxt.u_flag = s_r.u_saved;
        end

        case (s_r.st)
            ST_IDLE: begin
                s_nxt.offer_lvl = `NMI_LEVEL;
                s_nxt.offer_num = 6'h00;
                s_nxt.st        = ST_OFFER;
                // non-maskable sources ignore enable flag and levels
                if (s_r.p_undef) begin
                    s_nxt.offer_src = SRC_UNDEF;
                end else if (s_r.p_ovf) begin
                    s_nxt.offer_src = SRC_OVERFLOW;
                end else if (s_r.p_brk) begin
                    s_nxt.offer_src = SRC_BREAK;
                    s_nxt.offer_num = `NUM_BREAK_VAR;
                end else if (s_r.p_trap) begin
                    s_nxt.offer_src = SRC_TRAP;
                    s_nxt.offer_num = s_r.trap_num;
                end else if (s_r.p_dbg) begin
                    s_nxt.offer_src = SRC_DEBUG_BREAK;
                end else if (s_r.p_wdt) begin
                    s_nxt.offer_src = SRC_WATCHDOG;
                end else if (s_r.p_match) begin
                    s_nxt.offer_src = SRC_MATCH;
                end else if (s_r.p_step) begin
                    s_nxt.offer_src = SRC_STEP;
                end else if (best_hit) begin
                    s_nxt.offer_src = SRC_MASKABLE;
                    s_nxt.offer_num = {1'b0, best_num};
                    s_nxt.offer_lvl = best_lvl;
                end else begin
                    s_nxt.offer_src = SRC_NONE;
                    s_nxt.st        = ST_IDLE;
                end
                s_nxt.offer_vec = vec_of(s_nxt.offer_src, s_nxt.offer_num);
            end
            ST_OFFER: begin
                if (irq_ack) begin
                    s_nxt.st = ST_IDLE;
                    case (s_r.offer_src)
                        SRC_UNDEF:       s_nxt.p_undef = insn_done && insn_kind == IK_UNDEF;
                        SRC_OVERFLOW:    s_nxt.p_ovf = insn_done && insn_kind == IK_OVERFLOW
                                                     && overflow_flag;
                        SRC_BREAK:       s_nxt.p_brk = insn_done && insn_kind == IK_BREAK;
                        SRC_TRAP:        s_nxt.p_trap = insn_done && insn_kind == IK_TRAP;
                        SRC_DEBUG_BREAK: s_nxt.p_dbg = debugger_break;
                        SRC_WATCHDOG:    s_nxt.p_wdt = watchdog_expire;
                        SRC_MATCH:       s_nxt.p_match = insn_start && match_enable
                                                       && insn_addr == match_addr;
                        SRC_STEP:        s_nxt.p_step = insn_done & debug_step_flag;
                        SRC_MASKABLE: begin
                            s_nxt.req[s_r.offer_num[4:0]] = set_vec[s_r.offer_num[4:0]];
                        end
                        default: ;
                    endcase
                    if (!(s_r.offer_src == SRC_TRAP && s_r.offer_num[5])) begin
                        s_nxt.u_saved = s_r.u_flag;
                        s_nxt.u_flag  = 1'b0;
                    end
                end else if (s_r.offer_src == SRC_MASKABLE && !eligible[s_r.offer_num[4:0]]) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_HOLD_RESET: begin
                if (reset_pin_n) begin
                    s_nxt.st        = ST_OFFER;
                    s_nxt.dev_reset = 1'b0;
                    s_nxt.offer_src = SRC_RESET;
                    s_nxt.offer_num = 6'h00;
                    s_nxt.offer_lvl = `NMI_LEVEL;
                    s_nxt.offer_vec = `VEC_RESET;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase

        // reset pin outranks everything
        if (!reset_pin_n) begin
            s_nxt           = '0;
            s_nxt.st        = ST_HOLD_RESET;
            s_nxt.dev_reset = 1'b1;
            s_nxt.ext_prev  = ext_now;
            s_nxt.key_prev  = key_input_pin;
            s_nxt.offer_src = SRC_NONE;
            s_nxt.u_flag    = `U_FLAG_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r           <= '0;
            s_r.st        <= ST_IDLE;
            s_r.offer_src <= SRC_NONE;
            s_r.key_prev  <= 1'b1;
            s_r.u_flag    <= `U_FLAG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign irq_valid      = (s_r.st == ST_OFFER);
    assign irq_src        = s_r.offer_src;
    assign irq_num        = s_r.offer_num;
    assign irq_level      = s_r.offer_lvl;
    assign irq_vector     = s_r.offer_vec;
    assign stack_sel_flag = s_r.u_flag;
    assign req_bits       = s_r.req;
    assign dev_reset      = s_r.dev_reset;

    a_soft_unmasked: assert property (@(posedge mclk) disable iff (rst)
        s_r.st == ST_IDLE && soft_any && reset_pin_n && !int_enable_flag
        |=> irq_valid && irq_level == `NMI_LEVEL)
        else $error("pending trap not offered");

    a_undef_raise: assert property (@(posedge mclk) disable iff (rst)
        insn_done && insn_kind == IK_UNDEF && reset_pin_n |=> s_r.p_undef)
        else $error("undefined opcode not recorded");

    a_ovf_gate: assert property (@(posedge mclk) disable iff (rst)
        insn_done && insn_kind == IK_OVERFLOW && !overflow_flag && !s_r.p_ovf
        |=> !s_r.p_ovf)
        else $error("overflow raised with flag clear");

    a_trap_low_stack: assert property (@(posedge mclk) disable iff (rst)
        irq_valid && irq_ack && irq_src == SRC_TRAP && !irq_num[5] && reset_pin_n
        && !return_from_int |=> !stack_sel_flag && s_r.u_saved == $past(stack_sel_flag))
        else $error("low trap did not switch stack");

    a_trap_high_stack: assert property (@(posedge mclk) disable iff (rst)
        irq_valid && irq_ack && irq_src == SRC_TRAP && irq_num[5] && reset_pin_n
        && !stack_sel_load && !return_from_int |=> $stable(stack_sel_flag))
        else $error("high trap changed stack select");

    a_reset_pin: assert property (@(posedge mclk) disable iff (rst)
        !reset_pin_n |=> dev_reset && !irq_valid)
        else $error("reset pin low without device reset");

    a_reset_vector: assert property (@(posedge mclk) disable iff (rst)
        s_r.st == ST_HOLD_RESET ##1 reset_pin_n
        |=> irq_valid && irq_src == SRC_RESET && irq_vector == `VEC_RESET)
        else $error("reset vector not offered");

    a_mask_accept: assert property (@(posedge mclk) disable iff (rst)
        $rose(irq_valid) && irq_src == SRC_MASKABLE
        |-> $past(int_enable_flag) && irq_level > $past(processor_priority_level))
        else $error("maskable offered while blocked");

    a_req_cleared: assert property (@(posedge mclk) disable iff (rst)
        irq_valid && irq_ack && irq_src == SRC_MASKABLE && reset_pin_n
        && !set_vec[irq_num[4:0]] |=> !s_r.req[$past(irq_num[4:0])])
        else $error("request bit not cleared on acceptance");

    a_brk_redirect: assert property (@(posedge mclk) disable iff (rst)
        $rose(irq_valid) && irq_src == SRC_BREAK && $past(brk_fixed_vector) == `BRK_VEC_BLANK
        |-> irq_vector == $past(vector_base_pointer))
        else $error("blank break vector not redirected");

    a_ext_edge: assert property (@(posedge mclk) disable iff (rst)
        reset_pin_n && ext_rise_sel[0] && ext_request0_pin && !s_r.ext_prev[0]
        |=> s_r.req[`NUM_EXT0])
        else $error("external rising edge missed");

endmodule

`default_nettype wire

// [verif/sequencer_model.sv]
// instruction sequencer model that accepts offers after a set delay
`timescale 1ns/1ps
`default_nettype none

module sequencer_model
    import interrupt_source_vector_map_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        irq_valid,
    input  wire src_e        irq_src,
    input  wire logic [5:0]  irq_num,
    input  wire logic [19:0] irq_vector,
    input  wire logic [3:0]  ack_delay,
    output logic             irq_ack,
    output src_e             acc_src,
    output logic [5:0]       acc_num,
    output logic [19:0]      acc_vec,
    output logic [7:0]       acc_cnt
);
    logic [3:0] wait_cnt;

    // hold ack until the edge that takes it, then record the offer
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_ack  <= 1'h0;
            wait_cnt <= 4'h0;
            acc_cnt  <= 8'h00;
            acc_src  <= SRC_NONE;
            acc_num  <= 6'h00;
            acc_vec  <= 20'h0_0000;
        end else if (irq_valid && irq_ack) begin
            irq_ack  <= 1'h0;
            wait_cnt <= 4'h0;
            acc_cnt  <= acc_cnt + 8'h01;
            acc_src  <= irq_src;
            acc_num  <= irq_num;
            acc_vec  <= irq_vector;
        end else if (irq_valid) begin
            wait_cnt <= wait_cnt + 4'h1;
            irq_ack  <= (wait_cnt >= ack_delay);
        end else begin
            wait_cnt <= 4'h0;
            irq_ack  <= 1'h0;
        end
    end
endmodule

`default_nettype wire

// [verif/testbench.sv]
// testbench for the interrupt source and vector map block
`include "interrupt_source_vector_map_params.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import interrupt_source_vector_map_pkg::*;
    logic mclk = 1'h0, rst = 1'h1, reset_pin_n = 1'h1, insn_start = 1'h0, insn_done = 1'h0;
    logic overflow_flag = 1'h0, debug_step_flag = 1'h0, match_enable = 1'h0;
    logic watchdog_expire = 1'h0, debugger_break = 1'h0, key_input_pin = 1'h1;
    logic ext_request0_pin = 1'h0, ext_request1_pin = 1'h1, int_enable_flag = 1'h0;
    logic stack_sel_in = 1'h0, stack_sel_load = 1'h0, return_from_int = 1'h0;
    logic [19:0]      insn_addr = 20'h0_0000, match_addr = 20'h0_4000;
    logic [19:0]      vector_base_pointer = 20'h0_1000;
    insn_kind_e       insn_kind = IK_NONE;
    logic [5:0]       insn_trap_num = 6'h00;
    logic [1:0]       ext_rise_sel = 2'h1;
    periph_evt_s      periph_evt = '0;
    logic [31:0][2:0] prio_level = {32{3'h3}};
    logic [31:0]      req_clear = 32'h0000_0000, brk_fixed_vector = 32'h0001_2345, req_bits;
    logic [2:0]       processor_priority_level = 3'h7, irq_level;
    logic [3:0]       ack_delay = 4'h0;
    logic             irq_ack, irq_valid, stack_sel_flag, dev_reset;
    src_e             irq_src, acc_src;
    logic [5:0]       irq_num, acc_num;
    logic [19:0]      irq_vector, acc_vec;
    logic [7:0]       acc_cnt;
    int               failures = 0, compares = 0, cycles = 0;

    interrupt_source_vector_map dut (.mclk, .rst, .reset_pin_n, .insn_start, .insn_addr,
        .insn_done, .insn_kind, .insn_trap_num, .overflow_flag, .debug_step_flag,
        .match_enable, .match_addr, .watchdog_expire, .debugger_break, .key_input_pin,
        .ext_request0_pin, .ext_request1_pin, .ext_rise_sel, .periph_evt, .prio_level,
        .req_clear, .int_enable_flag, .processor_priority_level, .vector_base_pointer,
        .brk_fixed_vector, .stack_sel_in, .stack_sel_load, .return_from_int, .irq_ack,
        .irq_valid, .irq_src, .irq_num, .irq_level, .irq_vector, .stack_sel_flag,
        .req_bits, .dev_reset);
    sequencer_model seq (.mclk, .rst, .irq_valid, .irq_src, .irq_num, .irq_vector,
        .ack_delay, .irq_ack, .acc_src, .acc_num, .acc_vec, .acc_cnt);

    always #2.5 mclk = ~mclk;

    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    task automatic chk1(string what, logic exp, logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk20(string what, logic [19:0] exp, logic [19:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_src(src_e exp, src_e got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch irq_src expected %s seen %s", exp.name(), got.name());
        end
    endtask

    function automatic logic [19:0] vv(int n);
        return vector_base_pointer + 20'(4 * n);
    endfunction

    task automatic insn(insn_kind_e k, logic [5:0] n);
        @(posedge mclk);
        insn_done <= 1'h1;
        insn_kind <= k;
        insn_trap_num <= n;
        @(posedge mclk);
        insn_done <= 1'h0;
    endtask

    task automatic start_at(logic [19:0] a);
        @(posedge mclk);
        insn_start <= 1'h1;
        insn_addr <= a;
        @(posedge mclk);
        insn_start <= 1'h0;
    endtask

    task automatic expect_irq(src_e s, logic [19:0] v);
        logic [7:0] c0;
        c0 = acc_cnt;
        for (int i = 0; i < 40 && acc_cnt === c0; i++) begin
            @(posedge mclk);
            #1;
        end
        chk1("offer taken", 1'h1, acc_cnt !== c0);
        chk_src(s, acc_src);
        chk20("irq_vector", v, acc_vec);
    endtask

    task automatic expect_none();
        logic [7:0] c0;
        c0 = acc_cnt;
        repeat (12) @(posedge mclk);
        #1;
        chk1("no offer", 1'h1, acc_cnt === c0);
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        reset_pin_n <= 1'h0;
        repeat (2) @(posedge mclk);
        #1 chk1("dev_reset", 1'h1, dev_reset);
        @(posedge mclk);
        reset_pin_n <= 1'h1;
        expect_irq(SRC_RESET, `VEC_RESET);
        insn(IK_UNDEF, 6'h00);
        expect_irq(SRC_UNDEF, `VEC_UNDEF);
        insn(IK_OVERFLOW, 6'h00);
        expect_none();
        @(posedge mclk);
        overflow_flag <= 1'h1;
        insn(IK_OVERFLOW, 6'h00);
        expect_irq(SRC_OVERFLOW, `VEC_OVERFLOW);
        insn(IK_BREAK, 6'h00);
        expect_irq(SRC_BREAK, `VEC_BREAK);
        @(posedge mclk);
        brk_fixed_vector <= `BRK_VEC_BLANK;
        insn(IK_BREAK, 6'h00);
        expect_irq(SRC_BREAK, vv(0));
        @(posedge mclk);
        stack_sel_in <= 1'h1;
        stack_sel_load <= 1'h1;
        insn(IK_TRAP, 6'h05);
        stack_sel_load <= 1'h0;
        expect_irq(SRC_TRAP, vv(5));
        @(posedge mclk);
        #1 chk1("stack_sel_flag", 1'h0, stack_sel_flag);
        @(posedge mclk);
        return_from_int <= 1'h1;
        @(posedge mclk);
        return_from_int <= 1'h0;
        #1 chk1("stack_sel_flag", 1'h1, stack_sel_flag);
        insn(IK_TRAP, 6'h28);
        expect_irq(SRC_TRAP, vv(40));
        @(posedge mclk);
        #1 chk1("stack_sel_flag", 1'h1, stack_sel_flag);
        @(posedge mclk);
        ack_delay <= 4'h3;
        watchdog_expire <= 1'h1;
        @(posedge mclk);
        watchdog_expire <= 1'h0;
        expect_irq(SRC_WATCHDOG, `VEC_WATCHDOG);
        @(posedge mclk);
        debugger_break <= 1'h1;
        @(posedge mclk);
        debugger_break <= 1'h0;
        expect_irq(SRC_DEBUG_BREAK, `VEC_DEBUG_BREAK);
        @(posedge mclk);
        debug_step_flag <= 1'h1;
        insn(IK_NONE, 6'h00);
        debug_step_flag <= 1'h0;
        expect_irq(SRC_STEP, `VEC_STEP);
        @(posedge mclk);
        match_enable <= 1'h1;
        start_at(20'h0_4001);
        expect_none();
        start_at(20'h0_4000);
        expect_irq(SRC_MATCH, `VEC_MATCH);
        @(posedge mclk);
        match_enable <= 1'h0;
        processor_priority_level <= 3'h2;
        periph_evt.timer_a0 <= 1'h1;
        @(posedge mclk);
        periph_evt <= '0;
        expect_none();
        chk1("req_bits[21]", 1'h1, req_bits[21]);
        @(posedge mclk);
        int_enable_flag <= 1'h1;
        processor_priority_level <= 3'h3;
        expect_none();
        @(posedge mclk);
        processor_priority_level <= 3'h2;
        @(posedge mclk);
        #1 chk20("irq_level", 20'h0_0003, 20'(irq_level));
        expect_irq(SRC_MASKABLE, vv(21));
        chk20("acc_num", 20'h0_0015, 20'(acc_num));
        @(posedge mclk);
        #1 chk1("req_bits[21]", 1'h0, req_bits[21]);
        @(posedge mclk);
        key_input_pin <= 1'h0;
        expect_irq(SRC_MASKABLE, vv(13));
        @(posedge mclk);
        periph_evt.uart0_rx <= 1'h1;
        @(posedge mclk);
        periph_evt <= '0;
        expect_irq(SRC_MASKABLE, vv(18));
        @(posedge mclk);
        ext_request0_pin <= 1'h1;
        expect_irq(SRC_MASKABLE, vv(29));
        @(posedge mclk);
        ext_request1_pin <= 1'h0;
        expect_irq(SRC_MASKABLE, vv(30));
        summarize();
    end
endmodule

`default_nettype wire
